// ==== rtl/dsau_pkg.sv ====
// package for the data-space access unit: address map, widths, request/answer carriers
// assumes one core clock; the processor pipeline drives the request carriers
`default_nettype none
package dsau_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned RAM_BYTES     = 2048;
  localparam int unsigned RAM_WORDS     = RAM_BYTES / 2;
  localparam int unsigned RAM_IDX_W     = 10;
  localparam int unsigned WINDOW_BIT    = 15;
  localparam logic [15:0] RAM_BASE      = 16'h0800;
  localparam logic [15:0] RAM_LIMIT     = 16'h0fff;
  localparam logic [15:0] SFR_LIMIT     = 16'h07ff;
  localparam logic [15:0] NEAR_LIMIT    = 16'h1fff;
  localparam int unsigned NEAR_W        = 13;
  localparam logic [15:0] BYTE_STEP     = 16'h0001;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  typedef enum logic [1:0] {
    DSAU_MODE_INDIRECT,
    DSAU_MODE_DIRECT16,
    DSAU_MODE_NEAR13
  } dsau_mode_t;

  typedef enum logic [1:0] {
    DSAU_EXT_NONE,
    DSAU_EXT_SIGN,
    DSAU_EXT_ZERO
  } dsau_ext_t;

  typedef struct packed {
    logic        valid;
    logic        is_byte;
    dsau_mode_t  mode;
    logic [15:0] pointer_register;
    logic [15:0] literal;
    logic        post_inc;
  } dsau_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        sfr_hit;
    logic        window_hit;
  } dsau_rd_t;
endpackage
`default_nettype wire

// ==== rtl/dsau_top.sv ====
// data-space access unit: read and write address paths, byte lanes, alignment trap
// assumes the core holds each request one cycle; sfr and window data come from outside
//
// Function
// - 16-bit byte addresses span 64 Kbytes
// - top address bit routes reads to program window
// - 2 Kbyte memory; unmapped reads return zero
// - low byte even address, high odd
// - post-increment by one byte, two word
// - byte read selects lane, lands low
// - byte write enables only matching lane
// - odd word access raises address error
// - misaligned read still completes instruction
// - misaligned write suppressed, then trap
// - byte load keeps register high byte
// - sign-extend widens 8-bit to 16-bit
// - zero-extend clears register high byte
// - 0x0000-0x07ff decodes as sfr space
// - unused sfr addresses read zero
// - memory-direct 13-bit field reaches near space
// - move-class reaches whole space, direct/indirect
// - separate read and write address paths
`default_nettype none
module dsau_top (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire dsau_pkg::dsau_req_t rd_req,
  input  wire dsau_pkg::dsau_req_t wr_req,
  input  wire logic [15:0]         wr_data,
  input  wire logic [15:0]         sfr_rdata,
  input  wire logic                sfr_rvalid,
  input  wire logic [15:0]         window_rdata,
  input  wire logic [15:0]         reg_old,
  input  wire logic                ext_valid,
  input  wire dsau_pkg::dsau_ext_t ext_op,
  output dsau_pkg::dsau_rd_t       rd_ans,
  output logic [15:0]              rd_addr_q,
  output logic [15:0]              wr_addr_q,
  output logic [15:0]              rd_ptr_next_q,
  output logic [15:0]              wr_ptr_next_q,
  output logic [15:0]              reg_new_q,
  output logic [1:0]               sfr_we_q,
  output logic [15:0]              sfr_wdata_q,
  output logic                     addr_error_q
);
  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ea_of(input dsau_pkg::dsau_req_t r);
    unique case (r.mode)
      dsau_pkg::DSAU_MODE_NEAR13:   ea_of = {3'h0, r.literal[dsau_pkg::NEAR_W-1:0]};
      dsau_pkg::DSAU_MODE_DIRECT16: ea_of = r.literal;
      default:                      ea_of = r.pointer_register;
    endcase
  endfunction

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= dsau_pkg::RAM_BASE) && (a <= dsau_pkg::RAM_LIMIT);
  endfunction

  function automatic logic in_sfr(input logic [15:0] a);
    in_sfr = (a <= dsau_pkg::SFR_LIMIT);
  endfunction

  function automatic logic [15:0] step_of(input dsau_pkg::dsau_req_t r);
    step_of = r.is_byte ? dsau_pkg::BYTE_STEP : dsau_pkg::WORD_STEP;
  endfunction

  // ----------------------------------------------------------------
  // independent read and write address paths
  // ----------------------------------------------------------------
  wire logic [15:0] rd_ea   = ea_of(rd_req);
  wire logic [15:0] wr_ea   = ea_of(wr_req);
  wire logic        rd_mis  = rd_req.valid && !rd_req.is_byte && rd_ea[0];
  wire logic        wr_mis  = wr_req.valid && !wr_req.is_byte && wr_ea[0];
  wire logic        rd_win  = rd_ea[dsau_pkg::WINDOW_BIT];
  wire logic        wr_win  = wr_ea[dsau_pkg::WINDOW_BIT];
  wire logic        rd_ram  = !rd_win && in_ram(rd_ea);
  wire logic        wr_ram  = !wr_win && in_ram(wr_ea) && wr_req.valid && !wr_mis;
  wire logic        rd_sfr  = in_sfr(rd_ea);
  wire logic        wr_sfr  = in_sfr(wr_ea) && wr_req.valid && !wr_mis;

  // byte lanes: lane 0 is the even address, lane 1 the odd one
  wire logic [1:0]  wr_lanes = wr_req.is_byte ? {wr_ea[0], !wr_ea[0]} : 2'h3;
  wire logic [15:0] wr_bytes = wr_req.is_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;

  localparam int unsigned RAM_IW = dsau_pkg::RAM_IDX_W;
  wire logic [RAM_IW-1:0] rd_idx = rd_ea[RAM_IW:1];
  wire logic [RAM_IW-1:0] wr_idx = wr_ea[RAM_IW:1];

  // ----------------------------------------------------------------
  // two byte-wide memories sharing the word decode
  // ----------------------------------------------------------------
  logic [7:0] mem_lo [dsau_pkg::RAM_WORDS];
  logic [7:0] mem_hi [dsau_pkg::RAM_WORDS];

  always_ff @(posedge clk) begin
    if (wr_ram && wr_lanes[0]) begin
      mem_lo[wr_idx] <= wr_bytes[7:0];
    end
    if (wr_ram && wr_lanes[1]) begin
      mem_hi[wr_idx] <= wr_bytes[15:8];
    end
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire logic [15:0] ram_word = {mem_hi[rd_idx], mem_lo[rd_idx]};
  // unused sfr locations answer zero when no peripheral claims them
  wire logic [15:0] sfr_word = sfr_rvalid ? sfr_rdata : dsau_pkg::ZERO_WORD;
  wire logic [15:0] raw_word = rd_win ? window_rdata :
                               rd_ram ? ram_word :
                               rd_sfr ? sfr_word : dsau_pkg::ZERO_WORD;
  wire logic [15:0] rd_value = rd_req.is_byte ?
                               {8'h00, (rd_ea[0] ? raw_word[15:8] : raw_word[7:0])} : raw_word;

  // ----------------------------------------------------------------
  // working-register result: byte load and extend operations
  // ----------------------------------------------------------------
  logic [15:0] reg_d;
  always_comb begin
    reg_d = reg_old;
    if (ext_valid) begin
      unique case (ext_op)
        dsau_pkg::DSAU_EXT_SIGN: reg_d = {{8{reg_old[7]}}, reg_old[7:0]};
        dsau_pkg::DSAU_EXT_ZERO: reg_d = {8'h00, reg_old[7:0]};
        default:                 reg_d = reg_old;
      endcase
    end else if (rd_req.valid) begin
      // a misaligned read still completes; the trap follows it
      reg_d = rd_req.is_byte ? {reg_old[15:8], rd_value[7:0]} : rd_value;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_ans        <= '0;
      rd_addr_q     <= '0;
      wr_addr_q     <= '0;
      rd_ptr_next_q <= '0;
      wr_ptr_next_q <= '0;
      reg_new_q     <= '0;
      sfr_we_q      <= '0;
      sfr_wdata_q   <= '0;
      addr_error_q  <= 1'b0;
    end else begin
      rd_ans.valid      <= rd_req.valid;
      rd_ans.data       <= rd_value;
      rd_ans.sfr_hit    <= rd_req.valid && rd_sfr;
      rd_ans.window_hit <= rd_req.valid && rd_win;
      rd_addr_q         <= rd_ea;
      wr_addr_q         <= wr_ea;
      rd_ptr_next_q     <= rd_req.pointer_register + (rd_req.post_inc ? step_of(rd_req) : 16'h0000);
      wr_ptr_next_q     <= wr_req.pointer_register + (wr_req.post_inc ? step_of(wr_req) : 16'h0000);
      reg_new_q         <= reg_d;
      sfr_we_q          <= wr_sfr ? wr_lanes : 2'h0;
      sfr_wdata_q       <= wr_bytes;
      addr_error_q      <= rd_mis || wr_mis;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mis_trap;
    @(posedge clk) disable iff (!resetn)
      (wr_req.valid && !wr_req.is_byte && wr_ea[0]) |=> addr_error_q;
  endproperty
  a_mis_trap: assert property (p_mis_trap) else $error("odd word write gave no trap");

  property p_byte_no_trap;
    @(posedge clk) disable iff (!resetn)
      (rd_req.is_byte && wr_req.is_byte) |=> !addr_error_q;
  endproperty
  a_byte_no_trap: assert property (p_byte_no_trap) else $error("byte access trapped");

  property p_wr_suppress;
    @(posedge clk) disable iff (!resetn)
      wr_mis |=> (sfr_we_q == 2'h0);
  endproperty
  a_wr_suppress: assert property (p_wr_suppress) else $error("misaligned write reached sfr");

  property p_byte_lane;
    @(posedge clk) disable iff (!resetn)
      (wr_sfr && wr_req.is_byte) |=> (sfr_we_q == {$past(wr_ea[0]), !$past(wr_ea[0])});
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("wrong byte lane enabled");

  property p_post_inc;
    @(posedge clk) disable iff (!resetn)
      (rd_req.post_inc) |=> (rd_ptr_next_q - $past(rd_req.pointer_register) ==
                             ($past(rd_req.is_byte) ? 16'h0001 : 16'h0002));
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer step wrong");

  property p_out_zero;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && !rd_win && !rd_ram && !rd_sfr) |=> (rd_ans.data == 16'h0000);
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("unmapped read not zero");

  property p_byte_high_keep;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && rd_req.is_byte && !ext_valid) |=> (reg_new_q[15:8] == $past(reg_old[15:8]));
  endproperty
  a_byte_high_keep: assert property (p_byte_high_keep) else $error("byte load touched high byte");

  property p_sign_ext;
    @(posedge clk) disable iff (!resetn)
      (ext_valid && ext_op == dsau_pkg::DSAU_EXT_SIGN) |=> (reg_new_q[15:8] == {8{$past(reg_old[7])}});
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

  property p_zero_ext;
    @(posedge clk) disable iff (!resetn)
      (ext_valid && ext_op == dsau_pkg::DSAU_EXT_ZERO) |=> (reg_new_q[15:8] == 8'h00);
  endproperty
  a_zero_ext: assert property (p_zero_ext) else $error("zero extension wrong");

  property p_window;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && rd_ea[15]) |=> rd_ans.window_hit && !rd_ans.sfr_hit;
  endproperty
  a_window: assert property (p_window) else $error("window decode wrong");

  property p_near;
    @(posedge clk) disable iff (!resetn)
      (rd_req.mode == dsau_pkg::DSAU_MODE_NEAR13) |=> (rd_addr_q <= dsau_pkg::NEAR_LIMIT);
  endproperty
  a_near: assert property (p_near) else $error("near address out of range");

  // ----------------------------------------------------------------
  // alignment faults, then read and write decode and pointer checks, seen over request and answer cycles
  // ----------------------------------------------------------------
  // a refused write must show the trap with every lane quiet
  sequence s_odd_word_write;
    wr_req.valid && !wr_req.is_byte && wr_ea[0];
  endsequence

  sequence s_trap_no_lane;
    addr_error_q && (sfr_we_q == 2'h0);
  endsequence

  property p_write_fault;
    @(posedge clk) disable iff (!resetn)
      s_odd_word_write |=> s_trap_no_lane;
  endproperty
  a_write_fault: assert property (p_write_fault) else $error("odd word write not refused");

  sequence s_odd_word_read;
    rd_req.valid && !rd_req.is_byte && rd_ea[0] && !ext_valid;
  endsequence

  sequence s_read_done_trap;
    addr_error_q && rd_ans.valid && (reg_new_q == rd_ans.data);
  endsequence

  property p_read_fault;
    @(posedge clk) disable iff (!resetn)
      s_odd_word_read |=> s_read_done_trap;
  endproperty
  a_read_fault: assert property (p_read_fault) else $error("odd word read did not complete");

  property p_byte_read_low;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && rd_req.is_byte) |=> (rd_ans.data[15:8] == 8'h00);
  endproperty
  a_byte_read_low: assert property (p_byte_read_low) else $error("byte read left high byte set");

  property p_sfr_unused;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && rd_sfr && !sfr_rvalid) |=> (rd_ans.data == dsau_pkg::ZERO_WORD);
  endproperty
  a_sfr_unused: assert property (p_sfr_unused) else $error("unused sfr read not zero");

  property p_sfr_decode;
    @(posedge clk) disable iff (!resetn)
      (rd_req.valid && (rd_ea <= dsau_pkg::SFR_LIMIT)) |=> (rd_ans.sfr_hit && !rd_ans.window_hit);
  endproperty
  a_sfr_decode: assert property (p_sfr_decode) else $error("sfr decode wrong");

  property p_idle_read;
    @(posedge clk) disable iff (!resetn)
      !rd_req.valid |=> !(rd_ans.valid || rd_ans.sfr_hit || rd_ans.window_hit);
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("answer without read request");

  property p_direct_write;
    @(posedge clk) disable iff (!resetn)
      (wr_req.mode == dsau_pkg::DSAU_MODE_DIRECT16) |=> (wr_addr_q == $past(wr_req.literal));
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct write address wrong");

  property p_ptr_hold;
    @(posedge clk) disable iff (!resetn)
      !rd_req.post_inc |=> (rd_ptr_next_q == $past(rd_req.pointer_register));
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without post increment");

  property p_wr_step;
    @(posedge clk) disable iff (!resetn)
      wr_req.post_inc |=> ((wr_ptr_next_q - $past(wr_req.pointer_register)) ==
                           ($past(wr_req.is_byte) ? dsau_pkg::BYTE_STEP : dsau_pkg::WORD_STEP));
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer step wrong");
endmodule
`default_nettype wire

// ==== tb/dsau_far_model.sv ====
// far-side model: peripheral and program-window read data for the read path
// assumes the core keeps the read fields steady through the answer cycle
`default_nettype none
module dsau_far_model (
  input  wire dsau_pkg::dsau_req_t rd_req,
  output logic [15:0]              sfr_rdata,
  output logic                     sfr_rvalid,
  output logic [15:0]              window_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] a;
  assign a = rd_req.mode == dsau_pkg::DSAU_MODE_INDIRECT ? rd_req.pointer_register :
             rd_req.mode == dsau_pkg::DSAU_MODE_DIRECT16 ? rd_req.literal : {3'h0, rd_req.literal[12:0]};
  // ----------------------------------------
  // answers
  // ----------------------------------------
  // upper part of the page left unused, so some sfr reads must come back zero
  assign sfr_rvalid   = ~a[8];
  assign sfr_rdata    = {a[7:0] ^ 8'h5a, a[7:0]};
  assign window_rdata = ~a;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the data-space access unit
// assumes one core clock; expectations come from a word-array model of the ram
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  dsau_pkg::dsau_req_t rd_req = '0;
  dsau_pkg::dsau_req_t wr_req = '0;
  logic [15:0]         wr_data = 16'h0;
  logic [15:0]         reg_old = 16'h0;
  logic                ext_valid = 1'b0;
  dsau_pkg::dsau_ext_t ext_op = dsau_pkg::DSAU_EXT_NONE;
  logic [15:0]         sfr_rdata, window_rdata, rd_addr_q, wr_addr_q, rd_ptr_next_q, wr_ptr_next_q;
  logic [15:0]         reg_new_q, sfr_wdata_q;
  logic                sfr_rvalid, addr_error_q;
  logic [1:0]          sfr_we_q;
  dsau_pkg::dsau_rd_t  rd_ans;
  int                  bad_count = 0;
  int                  checks = 0;
  logic [15:0]         lf = 16'h5c6d;
  logic [15:0]         mem [1024];
  logic [15:0]         spots [11] = '{16'h0202, 16'h0201, 16'h0300, 16'h07ff, 16'h0801, 16'h0ffe,
                                      16'h1000, 16'h1fff, 16'h7ffe, 16'h8001, 16'hfffe};
  always #12.5 clk = ~clk;
  dsau_top uut (.clk, .resetn, .rd_req, .wr_req, .wr_data, .sfr_rdata, .sfr_rvalid, .window_rdata,
    .reg_old, .ext_valid, .ext_op, .rd_ans, .rd_addr_q, .wr_addr_q, .rd_ptr_next_q, .wr_ptr_next_q,
    .reg_new_q, .sfr_we_q, .sfr_wdata_q, .addr_error_q);
  dsau_far_model far (.rd_req, .sfr_rdata, .sfr_rvalid, .window_rdata);
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [15:0] ea(dsau_pkg::dsau_req_t q);
    if (q.mode == dsau_pkg::DSAU_MODE_INDIRECT) return q.pointer_register;
    if (q.mode == dsau_pkg::DSAU_MODE_DIRECT16) return q.literal;
    return {3'h0, q.literal[12:0]};
  endfunction
  function automatic dsau_pkg::dsau_req_t mk(logic v, logic b, int m, logic [15:0] a, logic i);
    // near form gets junk above bit 12 so truncation shows
    return '{v, b, dsau_pkg::dsau_mode_t'(m), a, m == 2 ? (a | 16'he000) : a, i};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // ----------------------------------------
  // one request cycle on both paths, checked one cycle later
  // ----------------------------------------
  task automatic op(dsau_pkg::dsau_req_t r, dsau_pkg::dsau_req_t w, logic [15:0] d, logic xv, int xo);
    logic [15:0] ra, wa, wd, rd, ro, rn;
    logic        rer, wer, inram;
    logic [1:0]  lanes;
    @(negedge clk);
    rd_req = r;
    wr_req = w;
    wr_data = d;
    ext_valid = xv;
    ext_op = dsau_pkg::dsau_ext_t'(xo);
    reg_old = rnd();
    #1;
    ra = ea(r);
    wa = ea(w);
    ro = reg_old;
    rer = r.valid && !r.is_byte && ra[0];
    wer = w.valid && !w.is_byte && wa[0];
    wd = ra[15] ? window_rdata : ra <= 16'h07ff ? (sfr_rvalid ? sfr_rdata : 16'h0) :
         ra <= 16'h0fff ? mem[ra[10:1]] : 16'h0;
    rd = r.is_byte ? {8'h0, ra[0] ? wd[15:8] : wd[7:0]} : wd;
    rn = xv ? (xo == 1 ? {{8{ro[7]}}, ro[7:0]} : xo == 2 ? {8'h0, ro[7:0]} : ro) :
         !r.valid ? ro : r.is_byte ? {ro[15:8], rd[7:0]} : rd;
    lanes = (!w.valid || wer || wa > 16'h07ff) ? 2'b00 : !w.is_byte ? 2'b11 : wa[0] ? 2'b10 : 2'b01;
    @(posedge clk);
    @(negedge clk);
    chk("rd_valid", r.valid, rd_ans.valid);
    chk("addr_error", rer | wer, addr_error_q);
    chk("sfr_we", lanes, sfr_we_q);
    if (lanes != 2'b00) chk("sfr_wdata", w.is_byte ? {2{d[7:0]}} : d, sfr_wdata_q);
    if (r.valid) begin
      chk("rd_addr", ra, rd_addr_q);
      chk("rd_ptr", r.pointer_register + (r.post_inc ? (r.is_byte ? 16'h1 : 16'h2) : 16'h0), rd_ptr_next_q);
      chk("hits", {!ra[15] && ra <= 16'h07ff, ra[15]}, {rd_ans.sfr_hit, rd_ans.window_hit});
      if (!$isunknown(rd)) chk("rd_data", rd, rd_ans.data);
      if (!$isunknown(rn)) chk("reg_new", rn, reg_new_q);
    end else chk("reg_ext", rn, reg_new_q);
    if (w.valid) begin
      chk("wr_addr", wa, wr_addr_q);
      chk("wr_ptr", w.pointer_register + (w.post_inc ? (w.is_byte ? 16'h1 : 16'h2) : 16'h0), wr_ptr_next_q);
    end
    inram = w.valid && !wer && wa >= 16'h0800 && wa <= 16'h0fff;
    if (inram && !w.is_byte) mem[wa[10:1]] = d;
    if (inram && w.is_byte && wa[0]) mem[wa[10:1]][15:8] = d[7:0];
    if (inram && w.is_byte && !wa[0]) mem[wa[10:1]][7:0] = d[7:0];
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    // words into ram while reading the same word: read sees old data
    for (int i = 0; i < 8; i++) op(mk(1, 0, i % 3, 16'h0800 + 2 * i, 1), mk(1, 0, i % 3, 16'h0800 + 2 * i, 1), rnd(), 0, 0);
    // map corners, odd words, both sizes, all address forms
    foreach (spots[k]) op(mk(1, lf[0], k % 3, spots[k], lf[1]), mk(1, lf[2], k % 3, spots[k], lf[3]), rnd(), 0, 0);
    for (int i = 0; i < 16; i++) op(mk(1, i[0], i % 3, 16'h0800 + i, 1), mk(1, 1, 0, 16'h0800 + (i ^ 3), 0), rnd(), i[1], i % 3);
    op(mk(0, 0, 0, 16'h0, 0), mk(0, 0, 0, 16'h0, 0), 16'h0, 1, 1);
    op(mk(0, 0, 0, 16'h0, 0), mk(0, 0, 0, 16'h0, 0), 16'h0, 1, 2);
    for (int i = 0; i < 8; i++) op(mk(1, 0, 0, 16'h0800 + 2 * i, 0), mk(0, 0, 0, 16'h0, 0), 16'h0, 0, 0);
    stop_test();
  end
  initial begin
    #(25ns * 4000);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
